// ==== logic/stm_regs.svh ====
// Register offsets, field positions and timing constants of the monitor
`ifndef STM_REGS_SVH
`define STM_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define STM_ADDR_W 4
`define STM_OFS_CTRL 4'h0
`define STM_OFS_STATUS 4'h4
`define STM_OFS_TRIPCNT 4'h8

// ****************************************************************
// Control register fields (write one to act)
// ****************************************************************
`define STM_CTRL_START 0
`define STM_CTRL_MSG_CLR 1

// ****************************************************************
// Status register fields
// ****************************************************************
`define STM_ST_FILT_A 0
`define STM_ST_FILT_B 1
`define STM_ST_STATE_LO 2
`define STM_ST_STATE_HI 3
`define STM_ST_MSG 4
`define STM_ST_FAULT 5
`define STM_ST_RAW_A 6
`define STM_ST_RAW_B 7
`define STM_ST_RUNNING 8

// ****************************************************************
// Bus answers and reset values
// ****************************************************************
`define STM_RESP_OKAY 2'h0
`define STM_RESP_SLVERR 2'h2
`define STM_DATA_RST 32'h0000_0000
`define STM_CNT_W 16

// ****************************************************************
// Timing
// ****************************************************************
`define STM_CLK_MHZ 100
`define STM_TICK_US 1000
`define STM_TICK_CYC (`STM_CLK_MHZ * `STM_TICK_US)
`define STM_FILT_MS 6
`define STM_DIS_MIN_MS 1600
`define STM_DIS_MAX_MS 3000
`define STM_DIS_TRIP_MS ((`STM_DIS_MIN_MS + `STM_DIS_MAX_MS) / 2)

`endif

// ==== logic/stm_pkg.sv ====
// Types shared by the torque cutoff monitor
package stm_pkg;

  typedef enum logic [1:0] {
    STM_SAFE     = 2'b00,
    STM_RUN_OK   = 2'b01,
    STM_DISAGREE = 2'b10,
    STM_FAULT    = 2'b11
  } stm_state_e;

endpackage

// ==== logic/stm_tick.sv ====
// Millisecond enable pulse divided down from the system clock
`timescale 1ns/1ps
`default_nettype none
module stm_tick #(
  parameter int unsigned DIV = 100000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_q;
  wire last_w = (cnt_q == W'(DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= last_w ? '0 : cnt_q + 1'b1;
      tick_o <= last_w;
    end
  end
endmodule
`default_nettype wire

// ==== logic/stm_filter.sv ====
// Low-going filter for one request input
`timescale 1ns/1ps
`default_nettype none
module stm_filter #(
  parameter int unsigned FILT = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic raw_i,
  output logic filt_o
);
  localparam int W = $clog2(FILT + 1);

  logic [W-1:0] cnt_q;
  wire done_w = (cnt_q == W'(FILT - 1));

  // Low is taken on the FILT-th tick of continuous low, after at least FILT-1 whole tick periods
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      filt_o <= 1'b0;
    end else if (raw_i) begin
      cnt_q <= '0;
      filt_o <= 1'b1;
    end else if (filt_o && tick_i) begin
      cnt_q <= done_w ? '0 : cnt_q + 1'b1;
      filt_o <= !done_w;
    end
  end
endmodule
`default_nettype wire

// ==== logic/stm_monitor.sv ====
// Dual-channel torque cutoff input monitor with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "stm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module stm_monitor
  import stm_pkg::*;
#(
  parameter int unsigned TICK_CYC = `STM_TICK_CYC,
  parameter int unsigned FILT_MS = `STM_FILT_MS,
  parameter int unsigned DIS_TRIP_MS = `STM_DIS_TRIP_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic request_input_a_i,
  input wire logic request_input_b_i,
  input wire logic start_cmd_i,
  input wire logic running_i,
  output logic trip_o,
  output logic start_inhibit_o,
  output logic status_output_pos_o,
  output logic status_output_neg_o,
  output logic trip_msg_o,
  output logic trip_log_o,
  output logic fault_o,
  input wire logic [`STM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`STM_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // Address decode helper
  // ****************************************************************
  function automatic logic addr_hit(input logic [`STM_ADDR_W-1:0] a);
    addr_hit = (a == `STM_OFS_CTRL) || (a == `STM_OFS_STATUS) ||
               (a == `STM_OFS_TRIPCNT);
  endfunction

  localparam int DW = $clog2(DIS_TRIP_MS + 1);

  // ****************************************************************
  // Millisecond tick and input filters
  // ****************************************************************
  logic tick_w;
  logic [1:0] raw_w;
  logic [1:0] filt_w;

  assign raw_w = {request_input_b_i, request_input_a_i};

  stm_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick_w)
  );

  // Each channel filtered on its own so staggered test pulses pass
  for (genvar i = 0; i < 2; i++) begin : g_filt
    stm_filter #(
      .FILT(FILT_MS)
    ) u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_w),
      .raw_i(raw_w[i]),
      .filt_o(filt_w[i])
    );
  end

  // ****************************************************************
  // Input state decode
  // ****************************************************************
  wire both_low_w = !filt_w[0] && !filt_w[1];
  wire both_high_w = filt_w[0] && filt_w[1];
  wire differ_w = filt_w[0] ^ filt_w[1];

  // ****************************************************************
  // Disagreement timer
  // ****************************************************************
  logic [DW-1:0] dis_cnt_q;
  wire dis_expire_w = tick_w && (dis_cnt_q == DW'(DIS_TRIP_MS - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_cnt_q <= '0;
    end else if (!differ_w) begin
      dis_cnt_q <= '0;
    end else if (tick_w && !dis_expire_w) begin
      dis_cnt_q <= dis_cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // Monitor state machine
  // ****************************************************************
  stm_state_e state_q;
  stm_state_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      STM_SAFE, STM_RUN_OK, STM_DISAGREE: begin
        if (state_q == STM_DISAGREE && differ_w && dis_expire_w) begin
          state_d = STM_FAULT;
        end else if (both_low_w) begin
          state_d = STM_SAFE;
        end else if (both_high_w) begin
          state_d = STM_RUN_OK;
        end else begin
          state_d = STM_DISAGREE;
        end
      end
      STM_FAULT: begin
        state_d = STM_FAULT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= STM_SAFE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Drive outputs
  // ****************************************************************
  wire trip_w = (state_d != STM_RUN_OK);
  wire status_on_w = (state_d == STM_SAFE);

  // Registered straight from the next state to keep response short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o <= 1'b1;
      start_inhibit_o <= 1'b1;
      status_output_pos_o <= 1'b0;
      status_output_neg_o <= 1'b1;
      fault_o <= 1'b0;
    end else begin
      trip_o <= trip_w;
      start_inhibit_o <= trip_w;
      status_output_pos_o <= status_on_w;
      status_output_neg_o <= !status_on_w;
      fault_o <= (state_d == STM_FAULT);
    end
  end

  // ****************************************************************
  // Register bus: write channel
  // ****************************************************************
  logic aw_have_q;
  logic w_have_q;
  logic [`STM_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;

  wire aw_take_w = s_axi_awvalid && s_axi_awready;
  wire w_take_w = s_axi_wvalid && s_axi_wready;
  wire wr_go_w = aw_have_q && w_have_q;
  wire wr_ctrl_w = wr_go_w && (aw_addr_q == `STM_OFS_CTRL) && w_strb_q[0];
  wire soft_start_w = wr_ctrl_w && w_data_q[`STM_CTRL_START];
  wire msg_clr_w = wr_ctrl_w && w_data_q[`STM_CTRL_MSG_CLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= `STM_DATA_RST;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STM_RESP_OKAY;
    end else begin
      if (aw_take_w) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take_w) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go_w) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_hit(aw_addr_q) ? `STM_RESP_OKAY
                                           : `STM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Start attempts, trip message and trip history
  // ****************************************************************
  wire start_w = start_cmd_i || soft_start_w;
  logic trip_prev_q;
  logic [`STM_CNT_W-1:0] trip_cnt_q;

  wire start_trip_w = start_w && trip_w;
  wire run_trip_w = running_i && trip_w && !trip_prev_q;
  wire msg_set_w = start_trip_w || run_trip_w || (state_d == STM_FAULT);
  wire log_w = start_trip_w || run_trip_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_prev_q <= 1'b1;
      trip_msg_o <= 1'b0;
      trip_log_o <= 1'b0;
      trip_cnt_q <= '0;
    end else begin
      trip_prev_q <= trip_w;
      // Set wins over a clear in the same cycle
      if (msg_set_w) begin
        trip_msg_o <= 1'b1;
      end else if (msg_clr_w) begin
        trip_msg_o <= 1'b0;
      end
      trip_log_o <= log_w;
      if (log_w && !(&trip_cnt_q)) begin
        trip_cnt_q <= trip_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register bus: read channel
  // ****************************************************************
  logic [31:0] status_w;
  logic [31:0] rd_mux_w;

  always_comb begin
    status_w = `STM_DATA_RST;
    status_w[`STM_ST_FILT_A] = filt_w[0];
    status_w[`STM_ST_FILT_B] = filt_w[1];
    status_w[`STM_ST_STATE_HI:`STM_ST_STATE_LO] = state_q;
    status_w[`STM_ST_MSG] = trip_msg_o;
    status_w[`STM_ST_FAULT] = fault_o;
    status_w[`STM_ST_RAW_A] = raw_w[0];
    status_w[`STM_ST_RAW_B] = raw_w[1];
    status_w[`STM_ST_RUNNING] = running_i;
  end

  assign rd_mux_w =
    (s_axi_araddr == `STM_OFS_STATUS) ? status_w :
    (s_axi_araddr == `STM_OFS_TRIPCNT) ? 32'(trip_cnt_q) :
    `STM_DATA_RST;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `STM_DATA_RST;
      s_axi_rresp <= `STM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux_w;
      s_axi_rresp <= addr_hit(s_axi_araddr) ? `STM_RESP_OKAY
                                            : `STM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/stm_relay_model.sv ====
// Behavioural model of the external safety relays on both request lines
`timescale 1ns/1ps
`default_nettype none
module stm_relay_model #(
  parameter int unsigned PULSE_CYC = 19
) (
  input wire logic clk_i,
  input wire logic want_a_i,
  input wire logic want_b_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  output logic request_input_a_o,
  output logic request_input_b_o
);
  int unsigned pa_q;
  int unsigned pb_q;
  // ****************************************************************
  // Independent low test pulses per channel
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    pa_q <= pulse_a_i ? PULSE_CYC : (pa_q != 0 ? pa_q - 1 : 0);
    pb_q <= pulse_b_i ? PULSE_CYC : (pb_q != 0 ? pb_q - 1 : 0);
  end
  // Contact levels; skew between channels is set by the bench
  assign request_input_a_o = want_a_i && (pa_q == 0);
  assign request_input_b_o = want_b_i && (pb_q == 0);
endmodule
`default_nettype wire

// ==== testbench/stm_monitor_sva.sv ====
// Assertion checker for the torque cutoff monitor
`timescale 1ns/1ps
`default_nettype none
module stm_monitor_sva #(
  parameter int unsigned TICK_CYC = 100000,
  parameter int unsigned FILT_MS = 6,
  parameter int unsigned DIS_TRIP_MS = 2300
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic request_input_a_i,
  input wire logic request_input_b_i,
  input wire logic start_cmd_i,
  input wire logic running_i,
  input wire logic trip_o,
  input wire logic start_inhibit_o,
  input wire logic status_output_pos_o,
  input wire logic status_output_neg_o,
  input wire logic trip_msg_o,
  input wire logic trip_log_o,
  input wire logic fault_o,
  input wire logic s_axi_bvalid
);
  localparam int unsigned LIM = FILT_MS * TICK_CYC + 2;
  localparam int unsigned FLIM = (DIS_TRIP_MS + FILT_MS) * TICK_CYC + 3;
  localparam int unsigned FMIN = (DIS_TRIP_MS - 1) * TICK_CYC;
  wire logic ra = request_input_a_i;
  wire logic rb = request_input_b_i;
  int unsigned lo_a_q;
  int unsigned lo_b_q;
  int unsigned dis_q;
  int unsigned nh_q;
  // ****************************************************************
  // Run lengths of the raw inputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lo_a_q <= 0;
      lo_b_q <= 0;
      dis_q <= 0;
      nh_q <= 0;
    end else begin
      lo_a_q <= ra ? 0 : lo_a_q + 1;
      lo_b_q <= rb ? 0 : lo_b_q + 1;
      dis_q <= (ra != rb) ? dis_q + 1 : 0;
      nh_q <= (ra && rb) ? 0 : nh_q + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_run_in;
    ra && rb && !fault_o;
  endsequence
  sequence s_cut_start;
    start_cmd_i && trip_o && !$past(ra) && !$past(rb);
  endsequence
  a_status_pair:
  assert property (status_output_pos_o == !status_output_neg_o &&
    start_inhibit_o == trip_o && (!status_output_pos_o || trip_o))
    else $error("status pair broken");
  a_run_high:
  assert property (s_run_in [*4] |-> !trip_o && !status_output_pos_o)
    else $error("not running with both inputs high");
  a_dis_off:
  assert property (dis_q >= LIM |-> trip_o && !status_output_pos_o)
    else $error("disagreement not tripped");
  a_low_acts:
  assert property (lo_a_q >= LIM || lo_b_q >= LIM |-> trip_o)
    else $error("low input not acted on in time");
  a_pulse_ign:
  assert property (!$past(rst_i) && $rose(trip_o) |->
    $past(lo_a_q) >= 2 * TICK_CYC || $past(lo_b_q) >= 2 * TICK_CYC)
    else $error("trip on short pulse");
  a_fault_late:
  assert property (dis_q >= FLIM |-> fault_o)
    else $error("fault missing after long disagreement");
  a_fault_early:
  assert property ($rose(fault_o) |-> $past(nh_q) >= FMIN)
    else $error("fault declared too early");
  a_fault_hold:
  assert property (fault_o |=> fault_o && trip_o && !status_output_pos_o
    && trip_msg_o) else $error("fault state not held");
  a_msg_start:
  assert property (s_cut_start |=> trip_msg_o && trip_log_o)
    else $error("no message at start");
  a_log_cause:
  assert property (trip_log_o |-> $past(start_cmd_i) ||
    $past(running_i) || s_axi_bvalid) else $error("log without cause");
endmodule
bind stm_monitor stm_monitor_sva #(.TICK_CYC(TICK_CYC), .FILT_MS(FILT_MS),
  .DIS_TRIP_MS(DIS_TRIP_MS)) i_stm_monitor_sva (.clk_i, .rst_i,
  .request_input_a_i, .request_input_b_i, .start_cmd_i, .running_i,
  .trip_o, .start_inhibit_o, .status_output_pos_o, .status_output_neg_o,
  .trip_msg_o, .trip_log_o, .fault_o, .s_axi_bvalid);
`default_nettype wire

// ==== testbench/stm_monitor_tb.sv ====
// Self-checking bench of the torque cutoff monitor
`include "stm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module stm_monitor_tb import stm_pkg::*;;
  localparam int unsigned TK = 10;
  localparam int unsigned DT = 40;
  logic clk_i = 0, rst_i = 1, start_cmd_i = 0, running_i = 0;
  logic want_a = 0, want_b = 0, pul_a = 0, pul_b = 0;
  wire logic request_input_a_i, request_input_b_i;
  logic trip_o, start_inhibit_o, status_output_pos_o, status_output_neg_o;
  logic trip_msg_o, trip_log_o, fault_o;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int fail_count = 0, samples_checked = 0, cyc_n = 0, log_n = 0, exp_log = 0;
  stm_monitor #(.TICK_CYC(TK), .FILT_MS(6), .DIS_TRIP_MS(DT)) i_stm_monitor (
    .clk_i, .rst_i, .request_input_a_i, .request_input_b_i, .start_cmd_i,
    .running_i, .trip_o, .start_inhibit_o, .status_output_pos_o,
    .status_output_neg_o, .trip_msg_o, .trip_log_o, .fault_o,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  stm_relay_model #(.PULSE_CYC(19)) i_stm_relay_model (.clk_i,
    .want_a_i(want_a), .want_b_i(want_b), .pulse_a_i(pul_a),
    .pulse_b_i(pul_b), .request_input_a_o(request_input_a_i),
    .request_input_b_o(request_input_b_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    log_n += int'(trip_log_o);
    if (cyc_n == 4000) begin
      fail_count++;
      summarize();
    end
  end
  task summarize;
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_i);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk_i);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_i);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task start_p;
    @(posedge clk_i);
    start_cmd_i <= 1'b1;
    @(posedge clk_i);
    start_cmd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    tick(5);
    `CHK("trip", 1'b1, trip_o)
    `CHK("pos", 1'b1, status_output_pos_o)
    `CHK("inh", 1'b1, start_inhibit_o)
    `CHK("neg", 1'b0, status_output_neg_o)
    start_p();
    exp_log++;
    `CHK("msg", 1'b1, trip_msg_o)
    rdr(`STM_OFS_STATUS);
    `CHK("state", STM_SAFE, rd[3:2])
    wr(`STM_OFS_CTRL, 32'h2);
    want_a <= 1'b1;
    want_b <= 1'b1;
    running_i <= 1'b1;
    tick(5);
    `CHK("run", 1'b0, trip_o)
    `CHK("rinh", 1'b0, start_inhibit_o)
    `CHK("rneg", 1'b1, status_output_neg_o)
    start_p();
    pul_a <= 1'b1;
    tick(1);
    pul_a <= 1'b0;
    tick(30);
    pul_b <= 1'b1;
    tick(1);
    pul_b <= 1'b0;
    tick(60);
    `CHK("pulse", 1'b0, trip_o)
    want_a <= 1'b0;
    tick(40);
    `CHK("early", 1'b0, trip_o)
    tick(22);
    exp_log++;
    `CHK("cut", 1'b1, trip_o)
    `CHK("dis", 1'b0, status_output_pos_o)
    `CHK("dinh", 1'b1, start_inhibit_o)
    `CHK("msg", 1'b1, trip_msg_o)
    want_b <= 1'b0;
    running_i <= 1'b0;
    tick(62);
    `CHK("safe", 1'b1, status_output_pos_o)
    wr(`STM_OFS_CTRL, 32'h2);
    want_a <= 1'b1;
    want_b <= 1'b1;
    tick(5);
    want_a <= 1'b0;
    want_b <= 1'b0;
    tick(70);
    `CHK("idle", 1'b0, trip_msg_o)
    `CHK("log", exp_log, log_n)
    wr(`STM_OFS_CTRL, 32'h1);
    exp_log++;
    rdr(`STM_OFS_TRIPCNT);
    `CHK("cnt", exp_log, int'(rd))
    wr(`STM_OFS_CTRL, 32'h2);
    want_a <= 1'b1;
    tick(DT * TK - 2 * TK);
    `CHK("nofault", 1'b0, fault_o)
    `CHK("dmsg", 1'b0, trip_msg_o)
    tick(9 * TK);
    `CHK("fault", 1'b1, fault_o)
    want_b <= 1'b1;
    tick(10);
    wr(`STM_OFS_CTRL, 32'h2);
    `CHK("latch", 1'b1, trip_o)
    `CHK("fmsg", 1'b1, trip_msg_o)
    `CHK("fpos", 1'b0, status_output_pos_o)
    rdr(`STM_OFS_STATUS);
    `CHK("fbit", 1'b1, rd[`STM_ST_FAULT])
    wr(4'hC, 32'h1);
    `CHK("wresp", `STM_RESP_SLVERR, rsp)
    rdr(4'hC);
    `CHK("rresp", `STM_RESP_SLVERR, rsp)
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(6);
    `CHK("clear", 1'b0, fault_o)
    `CHK("rerun", 1'b0, trip_o)
    summarize();
  end
endmodule
`default_nettype wire
